/* address_calc_unit_map.svh */
`ifndef ADDRESS_CALC_UNIT_MAP_SVH
`define ADDRESS_CALC_UNIT_MAP_SVH

// ****************************************************************
// Datapath geometry
// ****************************************************************
`define ACU_ADDR_W 24
`define ACU_HALVES 2
`define ACU_SETS 4
`define ACU_SEL_W 2

// ****************************************************************
// Reset values of the register triplets
// ****************************************************************
`define ACU_ADDR_RST 24'h000000
`define ACU_OFF_RST 24'h000000
`define ACU_MOD_RST 24'hffffff

// ****************************************************************
// Modifier encodings
// ****************************************************************
`define ACU_MOD_LINEAR 24'hffffff
`define ACU_MOD_REVERSE 24'h000000
`define ACU_MOD_KIND_HI 23
`define ACU_MOD_KIND_LO 16
`define ACU_MOD_MWRAP_BIT 15
`define ACU_MOD_MWRAP_MASK 24'h007fff

// ****************************************************************
// Fixed increments
// ****************************************************************
`define ACU_STEP_UP 24'h000001
`define ACU_STEP_DOWN 24'hffffff

`endif

/* address_calc_unit_pkg.sv */
`include "address_calc_unit_map.svh"

package address_calc_unit_pkg;

    typedef logic [`ACU_ADDR_W-1:0] word_t;
    typedef logic [`ACU_SEL_W-1:0] sel_t;

    typedef enum logic [1:0] {
        ARITH_LINEAR,
        ARITH_MODULO,
        ARITH_MULTI_WRAP,
        ARITH_REVERSE
    } arith_e;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_NO_UPDATE,
        OP_POST_INC,
        OP_POST_DEC,
        OP_POST_ADD_OFF,
        OP_POST_SUB_OFF,
        OP_PRE_DEC,
        OP_INDEXED,
        OP_WR_ADDR,
        OP_WR_OFF,
        OP_WR_MOD,
        OP_RD_ADDR,
        OP_RD_OFF,
        OP_RD_MOD
    } acu_op_e;

    typedef struct packed {
        logic valid;
        acu_op_e op;
        sel_t sel;
        word_t data;
    } acu_req_s;

    typedef struct packed {
        logic valid;
        word_t addr;
    } acu_bus_s;

    typedef struct packed {
        logic valid;
        word_t data;
    } acu_rd_s;

endpackage : address_calc_unit_pkg

/* address_alu_calc.sv */
`timescale 1ns/10ps
`default_nettype none

`include "address_calc_unit_map.svh"

module address_alu_calc (
    input wire logic [23:0] addr_i,
    input wire logic [23:0] operand_i,
    input wire logic [23:0] mod_i,
    output logic [23:0] next_addr_o,
    output address_calc_unit_pkg::arith_e mode_o
);
    import address_calc_unit_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic word_t rev(input word_t v);
        word_t r;
        r = '0;
        for (int i = 0; i < `ACU_ADDR_W; i++) begin
            r[i] = v[`ACU_ADDR_W-1-i];
        end
        return r;
    endfunction : rev

    // Ones from the top set bit of the modulus downward give the buffer base mask.
    function automatic word_t smear(input word_t v);
        word_t r;
        r = v;
        for (int i = 1; i < `ACU_ADDR_W; i = i * 2) begin
            r = r | (r >> i);
        end
        return r;
    endfunction : smear

    word_t off_sum;
    word_t rev_sum;
    word_t mod_sum;
    word_t mod_term;
    word_t mask;
    word_t base;
    word_t upper;
    word_t wrap_mask;
    arith_e mode;

    // ****************************************************************
    // Modifier decode
    // ****************************************************************
    always_comb begin
        if (mod_i == `ACU_MOD_LINEAR) begin
            mode = ARITH_LINEAR;
        end else if (mod_i == `ACU_MOD_REVERSE) begin
            mode = ARITH_REVERSE;
        end else if (mod_i[`ACU_MOD_KIND_HI:`ACU_MOD_KIND_LO] != '0) begin
            mode = ARITH_LINEAR;
        end else if (mod_i[`ACU_MOD_MWRAP_BIT]) begin
            mode = ARITH_MULTI_WRAP;
        end else begin
            mode = ARITH_MODULO;
        end
    end

    // ****************************************************************
    // Adders and result selection
    // ****************************************************************
    always_comb begin
        off_sum = addr_i + operand_i;
        // The reverse-carry adder shares inputs; its carry runs top to bottom.
        rev_sum = rev(rev(addr_i) + rev(operand_i));
        mask = smear(mod_i);
        base = addr_i & ~mask;
        upper = base + mod_i;
        // Only one wrap is applied, so a step larger than the buffer is not folded fully.
        if (!operand_i[`ACU_ADDR_W-1] && off_sum > upper) begin
            mod_term = ~mod_i;
        end else if (operand_i[`ACU_ADDR_W-1] && off_sum < base) begin
            mod_term = mod_i + `ACU_STEP_UP;
        end else begin
            mod_term = '0;
        end
        mod_sum = off_sum + mod_term;
        wrap_mask = mod_i & `ACU_MOD_MWRAP_MASK;
        case (mode)
            ARITH_MODULO: next_addr_o = mod_sum;
            ARITH_MULTI_WRAP: next_addr_o = (addr_i & ~wrap_mask) | (off_sum & wrap_mask);
            ARITH_REVERSE: next_addr_o = rev_sum;
            default: next_addr_o = off_sum;
        endcase
        mode_o = mode;
    end

endmodule : address_alu_calc

`default_nettype wire

/* address_calc_unit.sv */
// Function
// - two identical ALUs, four register triplets each
// - linear, modulo, multi-wrap and reverse-carry arithmetic
// - 24-bit offset adder sums address and operand
// - modulo adder adds offset sum and plus or minus (modulus + 1) on a wrap
// - reverse-carry adder in parallel, carry downward
// - selector picks one adder result
// - one register update per ALU per cycle
// - modifier register value decodes the arithmetic

`timescale 1ns/10ps
`default_nettype none

`include "address_calc_unit_map.svh"

module address_calc_unit (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire address_calc_unit_pkg::acu_req_s [1:0] req_i,
    output address_calc_unit_pkg::acu_bus_s [1:0] bus_o,
    output address_calc_unit_pkg::acu_rd_s [1:0] rd_o,
    output address_calc_unit_pkg::arith_e [1:0] mode_o,
    output logic [1:0] updated_o
);
    import address_calc_unit_pkg::*;

    // ****************************************************************
    // Register triplets
    // ****************************************************************
    word_t triplet_addr [`ACU_HALVES][`ACU_SETS];
    word_t triplet_off [`ACU_HALVES][`ACU_SETS];
    word_t triplet_mod [`ACU_HALVES][`ACU_SETS];
    word_t next_addr [`ACU_HALVES][`ACU_SETS];
    word_t next_off [`ACU_HALVES][`ACU_SETS];
    word_t next_mod [`ACU_HALVES][`ACU_SETS];

    acu_bus_s [1:0] bus;
    acu_bus_s [1:0] next_bus;
    acu_rd_s [1:0] rd;
    acu_rd_s [1:0] next_rd;
    arith_e [1:0] mode;
    arith_e [1:0] next_mode;
    logic [1:0] updated;
    logic [1:0] next_updated;

    word_t cur_addr [`ACU_HALVES];
    word_t cur_off [`ACU_HALVES];
    word_t cur_mod [`ACU_HALVES];
    word_t operand [`ACU_HALVES];
    word_t calc_addr [`ACU_HALVES];
    arith_e calc_mode [`ACU_HALVES];

    // ****************************************************************
    // Operand choice
    // ****************************************************************
    // Both decrements use the same step; only the address put on the bus differs.
    function automatic word_t pick_operand(input acu_op_e op, input word_t off);
        word_t r;
        case (op)
            OP_POST_INC: r = `ACU_STEP_UP;
            OP_POST_DEC: r = `ACU_STEP_DOWN;
            OP_PRE_DEC: r = `ACU_STEP_DOWN;
            OP_POST_ADD_OFF: r = off;
            OP_INDEXED: r = off;
            OP_POST_SUB_OFF: r = ~off + `ACU_STEP_UP;
            default: r = '0;
        endcase
        return r;
    endfunction : pick_operand

    // Tells whether an operation writes its computed address back.
    function automatic logic writes_back(input acu_op_e op);
        logic r;
        case (op)
            OP_POST_INC: r = 1'b1;
            OP_POST_DEC: r = 1'b1;
            OP_POST_ADD_OFF: r = 1'b1;
            OP_POST_SUB_OFF: r = 1'b1;
            OP_PRE_DEC: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : writes_back

    // ****************************************************************
    // Two address ALUs
    // ****************************************************************
    generate
        for (genvar h = 0; h < `ACU_HALVES; h++) begin : g_half
            // The request picks the triplet, so a write is seen by the very next request.
            always_comb begin
                cur_addr[h] = triplet_addr[h][req_i[h].sel];
                cur_off[h] = triplet_off[h][req_i[h].sel];
                cur_mod[h] = triplet_mod[h][req_i[h].sel];
                operand[h] = pick_operand(req_i[h].op, cur_off[h]);
            end

            address_alu_calc u_calc (
                .addr_i(cur_addr[h]),
                .operand_i(operand[h]),
                .mod_i(cur_mod[h]),
                .next_addr_o(calc_addr[h]),
                .mode_o(calc_mode[h])
            );
        end
    endgenerate

    // ****************************************************************
    // Next-state computation
    // ****************************************************************
    always_comb begin
        next_addr = triplet_addr;
        next_off = triplet_off;
        next_mod = triplet_mod;
        next_mode = mode;
        for (int h = 0; h < `ACU_HALVES; h++) begin
            next_bus[h] = '0;
            next_rd[h] = '0;
            next_updated[h] = 1'b0;
            // Each half takes one request, so at most one of its triplets changes.
            if (req_i[h].valid) begin
                case (req_i[h].op)
                    OP_NO_UPDATE: begin
                        next_bus[h].valid = 1'b1;
                        next_bus[h].addr = cur_addr[h];
                    end
                    OP_POST_INC, OP_POST_DEC, OP_POST_ADD_OFF, OP_POST_SUB_OFF: begin
                        next_bus[h].valid = 1'b1;
                        next_bus[h].addr = cur_addr[h];
                    end
                    OP_PRE_DEC, OP_INDEXED: begin
                        next_bus[h].valid = 1'b1;
                        next_bus[h].addr = calc_addr[h];
                    end
                    OP_WR_ADDR: begin
                        next_addr[h][req_i[h].sel] = req_i[h].data;
                    end
                    OP_WR_OFF: begin
                        next_off[h][req_i[h].sel] = req_i[h].data;
                    end
                    OP_WR_MOD: begin
                        next_mod[h][req_i[h].sel] = req_i[h].data;
                    end
                    OP_RD_ADDR: begin
                        next_rd[h].valid = 1'b1;
                        next_rd[h].data = cur_addr[h];
                    end
                    OP_RD_OFF: begin
                        next_rd[h].valid = 1'b1;
                        next_rd[h].data = cur_off[h];
                    end
                    OP_RD_MOD: begin
                        next_rd[h].valid = 1'b1;
                        next_rd[h].data = cur_mod[h];
                    end
                    default: begin
                        next_bus[h] = '0;
                    end
                endcase
                if (writes_back(req_i[h].op)) begin
                    next_addr[h][req_i[h].sel] = calc_addr[h];
                    next_updated[h] = 1'b1;
                end
                if (writes_back(req_i[h].op) || req_i[h].op == OP_INDEXED) begin
                    next_mode[h] = calc_mode[h];
                end
            end
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    // Triplets leave reset as linear pointers at address zero.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int h = 0; h < `ACU_HALVES; h++) begin
                for (int s = 0; s < `ACU_SETS; s++) begin
                    triplet_addr[h][s] <= `ACU_ADDR_RST;
                    triplet_off[h][s] <= `ACU_OFF_RST;
                    triplet_mod[h][s] <= `ACU_MOD_RST;
                end
            end
        end else begin
            triplet_addr <= next_addr;
            triplet_off <= next_off;
            triplet_mod <= next_mod;
        end
    end

    // ****************************************************************
    // Output registers
    // ****************************************************************
    // Every port comes from here, so the address buses never see adder glitches.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int h = 0; h < `ACU_HALVES; h++) begin
                mode[h] <= ARITH_LINEAR;
            end
            bus <= '0;
            rd <= '0;
            updated <= '0;
        end else begin
            bus <= next_bus;
            rd <= next_rd;
            mode <= next_mode;
            updated <= next_updated;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign bus_o = bus;
    assign rd_o = rd;
    assign mode_o = mode;
    assign updated_o = updated;

endmodule : address_calc_unit

`default_nettype wire

/* xy_mem_sink.sv */
`timescale 1ns/10ps
`default_nettype none

// ****
// Memory side of the X and Y address buses.
// ****
module xy_mem_sink
    import address_calc_unit_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire address_calc_unit_pkg::acu_bus_s [1:0] bus_i,
    output logic [1:0][23:0] hits_o
);
    logic [1:0][23:0] next_hits;

    // Only counts accesses; a memory never pushes back on the address buses.
    always_comb begin
        for (int h = 0; h < 2; h++) begin
            next_hits[h] = hits_o[h] + {23'h0, bus_i[h].valid};
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hits_o <= '0;
        end else begin
            hits_o <= next_hits;
        end
    end
endmodule : xy_mem_sink

`default_nettype wire

/* address_calc_unit_props.sv */
`timescale 1ns/10ps
`default_nettype none

module address_calc_unit_checker
    import address_calc_unit_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire address_calc_unit_pkg::acu_req_s [1:0] req_i,
    input wire address_calc_unit_pkg::acu_bus_s [1:0] bus_o,
    input wire address_calc_unit_pkg::acu_rd_s [1:0] rd_o,
    input wire address_calc_unit_pkg::arith_e [1:0] mode_o,
    input wire logic [1:0] updated_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    AST_IDLE_QUIET: assert property (
        !req_i[0].valid |=> !bus_o[0].valid && !updated_o[0] && $stable(mode_o[0]))
        else $error("idle cycle produced output");
    AST_STEP_UPD: assert property (
        req_i[0].valid && req_i[0].op inside {OP_POST_INC, OP_POST_DEC, OP_POST_ADD_OFF,
        OP_POST_SUB_OFF, OP_PRE_DEC} |=> updated_o[0] && bus_o[0].valid)
        else $error("stepping op gave no update");
    AST_UPD_CAUSE: assert property (
        updated_o[1] |-> $past(req_i[1].valid && req_i[1].op inside {OP_POST_INC,
        OP_POST_DEC, OP_POST_ADD_OFF, OP_POST_SUB_OFF, OP_PRE_DEC}))
        else $error("update without stepping op");
    AST_LIN_STEP: assert property (
        (req_i[0].valid && req_i[0].op == OP_POST_INC) ##1 (req_i[0].valid &&
        req_i[0].op == OP_POST_INC && $stable(req_i[0].sel)) ##1 mode_o[0] == ARITH_LINEAR
        |-> bus_o[0].addr == $past(bus_o[0].addr) + 24'h1)
        else $error("linear increment wrong");
    AST_WR_QUIET: assert property (
        req_i[1].valid && req_i[1].op inside {OP_WR_ADDR, OP_WR_OFF, OP_WR_MOD}
        |=> !bus_o[1].valid && !updated_o[1] && !rd_o[1].valid)
        else $error("write produced a pulse");
    AST_WR_RD: assert property (
        (req_i[1].valid && req_i[1].op == OP_WR_ADDR) ##1 (req_i[1].valid &&
        req_i[1].op == OP_RD_ADDR && $stable(req_i[1].sel))
        |=> rd_o[1].valid && rd_o[1].data == $past(req_i[1].data, 2))
        else $error("address readback wrong");
    AST_REV_MODE: assert property (
        (req_i[0].valid && req_i[0].op == OP_WR_MOD && req_i[0].data == 24'h0) ##1
        (req_i[0].valid && req_i[0].op == OP_POST_INC && $stable(req_i[0].sel))
        |=> mode_o[0] == ARITH_REVERSE)
        else $error("reverse mode not decoded");
    AST_MWRAP_MODE: assert property (
        (req_i[1].valid && req_i[1].op == OP_WR_MOD && req_i[1].data == 24'h00800f) ##1
        (req_i[1].valid && req_i[1].op == OP_POST_INC && $stable(req_i[1].sel))
        |=> mode_o[1] == ARITH_MULTI_WRAP)
        else $error("multi wrap mode not decoded");
    AST_INDEXED: assert property (
        req_i[0].valid && req_i[0].op == OP_INDEXED |=> bus_o[0].valid && !updated_o[0])
        else $error("indexed op wrong");
endmodule : address_calc_unit_checker

bind address_calc_unit address_calc_unit_checker chk_u (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .req_i(req_i), .bus_o(bus_o), .rd_o(rd_o), .mode_o(mode_o),
    .updated_o(updated_o));

`default_nettype wire

/* test_address_calc_unit.sv */
`timescale 1ns/10ps
`default_nettype none

module test_address_calc_unit;
    import address_calc_unit_pkg::*;

    logic ref_clk_i;
    logic nrst_i;
    acu_req_s [1:0] req_i;
    acu_bus_s [1:0] bus_o;
    acu_rd_s [1:0] rd_o;
    arith_e [1:0] mode_o;
    logic [1:0] updated_o;
    logic [1:0][23:0] hits;
    word_t ma [2][4];
    word_t mo [2][4];
    word_t mm [2][4];
    acu_bus_s eb [2];
    acu_rd_s er [2];
    logic eu [2];
    arith_e em [2];
    int nb [2];
    int errors = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'he9d7;
    acu_req_s q0;
    acu_req_s q1;
    word_t mtab [8] = '{24'hffffff, 24'h000000, 24'h000007, 24'h00000c, 24'h00800f,
                        24'h000003, 24'h010000, 24'h008003};

    address_calc_unit dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req_i),
        .bus_o(bus_o), .rd_o(rd_o), .mode_o(mode_o), .updated_o(updated_o));
    xy_mem_sink mem_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus_i(bus_o), .hits_o(hits));

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // ****
    // Reference model
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic word_t rv(input word_t v);
        for (int i = 0; i < 24; i++) rv[i] = v[23-i];
    endfunction : rv

    function automatic word_t calc(input word_t a, input word_t d, input word_t m,
                                   output arith_e k);
        word_t s;
        word_t lo;
        lo = a;
        for (int i = 0; i < 24; i++) if (m >= (24'h1 << i)) lo[i] = 1'b0;
        s = a + d;
        k = ARITH_LINEAR;
        if (m == 24'h0) begin
            k = ARITH_REVERSE;
            s = rv(rv(a) + rv(d));
        end else if (m != 24'hffffff && m[23:16] == 8'h0 && m[15]) begin
            k = ARITH_MULTI_WRAP;
            s = (a & ~(m & 24'h007fff)) | (s & m & 24'h007fff);
        end else if (m != 24'hffffff && m[23:16] == 8'h0) begin
            // Single wrap only, so offsets are kept within one buffer size.
            k = ARITH_MODULO;
            if (!d[23] && s > lo + m) s = s - m - 24'h1;
            else if (d[23] && s < lo) s = s + m + 24'h1;
        end
        return s;
    endfunction : calc

    task automatic model(input int h, input acu_req_s q);
        word_t a;
        word_t r;
        word_t d;
        arith_e k;
        a = ma[h][q.sel];
        eb[h] = '0;
        er[h] = '0;
        eu[h] = 1'b0;
        if (!q.valid) return;
        case (q.op)
            OP_NO_UPDATE: eb[h] = {1'b1, a};
            OP_POST_INC, OP_POST_DEC, OP_POST_ADD_OFF, OP_POST_SUB_OFF, OP_PRE_DEC,
            OP_INDEXED: begin
                d = mo[h][q.sel];
                if (q.op == OP_POST_INC) d = 24'h1;
                if (q.op inside {OP_POST_DEC, OP_PRE_DEC}) d = 24'hffffff;
                if (q.op == OP_POST_SUB_OFF) d = -d;
                r = calc(a, d, mm[h][q.sel], k);
                em[h] = k;
                eb[h] = {1'b1, (q.op inside {OP_PRE_DEC, OP_INDEXED}) ? r : a};
                if (q.op != OP_INDEXED) ma[h][q.sel] = r;
                eu[h] = q.op != OP_INDEXED;
            end
            OP_WR_ADDR: ma[h][q.sel] = q.data;
            OP_WR_OFF: mo[h][q.sel] = q.data;
            OP_WR_MOD: mm[h][q.sel] = q.data;
            OP_RD_ADDR: er[h] = {1'b1, a};
            OP_RD_OFF: er[h] = {1'b1, mo[h][q.sel]};
            OP_RD_MOD: er[h] = {1'b1, mm[h][q.sel]};
            default: ;
        endcase
        nb[h] += int'(eb[h].valid);
    endtask : model

    task automatic rst_model();
        for (int h = 0; h < 2; h++) begin
            ma[h] = '{default: 24'h0};
            mo[h] = '{default: 24'h0};
            mm[h] = '{default: 24'hffffff};
            eb[h] = '0;
            er[h] = '0;
            eu[h] = 1'b0;
            em[h] = ARITH_LINEAR;
            nb[h] = 0;
        end
    endtask : rst_model

    // ****
    // Stimulus and checks
    // ****
    task automatic cmp_val(input logic [24:0] got, input logic [24:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_st(input logic [2:0] got, input logic [2:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_st

    task automatic chk_out();
        for (int h = 0; h < 2; h++) begin
            cmp_val(bus_o[h], eb[h]);
            cmp_val(rd_o[h], er[h]);
            cmp_st({updated_o[h], mode_o[h]}, {eu[h], em[h]});
        end
    endtask : chk_out

    task automatic step(input acu_req_s a, input acu_req_s b);
        req_i[0] = a;
        req_i[1] = b;
        model(0, a);
        model(1, b);
        @(posedge ref_clk_i);
        #1;
        chk_out();
    endtask : step

    function automatic acu_req_s mk(input acu_op_e op, input sel_t s, input word_t d);
        return {1'b1, op, s, d};
    endfunction : mk

    task automatic rnd(output acu_req_s q);
        repeat (9) seed = lfsr(seed);
        q.valid = seed[0] | seed[1];
        q.op = acu_op_e'(seed[5:2]);
        q.sel = seed[7:6];
        q.data = seed[31:8];
        if (q.op == OP_WR_MOD) q.data = mtab[seed[10:8]];
        if (q.op == OP_WR_OFF) q.data = {22'h0, seed[9:8]};
    endtask : rnd

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        nrst_i = 1'b0;
        req_i = '0;
        rst_model();
        repeat (12) @(posedge ref_clk_i);
        #1;
        nrst_i = 1'b1;
        step(mk(OP_RD_MOD, 2'd3, 24'h0), mk(OP_RD_OFF, 2'd2, 24'h0));
        step(mk(OP_WR_MOD, 2'd0, 24'h0), mk(OP_WR_MOD, 2'd1, 24'h00800f));
        step(mk(OP_POST_INC, 2'd0, 24'h0), mk(OP_POST_INC, 2'd1, 24'h0));
        step(mk(OP_POST_INC, 2'd3, 24'h0), mk(OP_WR_ADDR, 2'd1, 24'h12345e));
        step(mk(OP_POST_INC, 2'd3, 24'h0), mk(OP_RD_ADDR, 2'd1, 24'h0));
        step(mk(OP_INDEXED, 2'd3, 24'h0), mk(OP_POST_INC, 2'd1, 24'h0));
        step('0, mk(OP_POST_INC, 2'd1, 24'h0));
        $display("test directed done");
        for (int i = 0; i < 1500; i++) begin
            rnd(q0);
            rnd(q1);
            step(q0, q1);
        end
        $display("test random done");
        nrst_i = 1'b0;
        req_i = '0;
        rst_model();
        #2;
        chk_out();
        repeat (12) @(posedge ref_clk_i);
        #1;
        nrst_i = 1'b1;
        for (int i = 0; i < 300; i++) begin
            rnd(q0);
            rnd(q1);
            step(q0, q1);
        end
        // One idle cycle lets the memory side count the last pulse.
        step('0, '0);
        for (int h = 0; h < 2; h++) cmp_val({1'b0, hits[h]}, 25'(nb[h]));
        $display("test reset done");
        give_verdict();
    end
endmodule : test_address_calc_unit

`default_nettype wire
